// ---- rtl/mdc_margin_dac_control.v ----
// Behaviour
// - Each channel takes an 8-bit unsigned code, 256 settings, output linear in code.
// - Code 0x7F maps to the selected midscale offset; step is 0.6015 V over 255.
// - Each channel selects one of four midscale offsets: 0.6, 0.8, 1.0, 1.25 V.
// - Code span is 128 codes up and 127 down around midcode.
// - Drive code when within limits; else substitute lower or upper limit.
// - Lower limit above upper limit forces output buffer high impedance, any enable.
// - Both limits of every channel load from nonvolatile storage at startup.
// - On enable, buffer first tracks the pin, then switches to converter and drives.
// - A new host code write changes the channel's margining output.
// - Four independent channels, each with code, limits, range and enable.
// - Host transactions are refused until startup download including limits completes.
`timescale 1ns/1ps
`include "mdc_map.vh"
module mdc_margin_dac_control #(
  parameter CH = `MDC_CH_NUM,
  parameter TRACK_CYC = `MDC_TRACK_CYC
) (
  input wire sys_clk,
  input wire nrst,
  input wire cfg_load,
  input wire [CH*8-1:0] cfg_upper_code_limit,
  input wire [CH*8-1:0] cfg_lower_code_limit,
  input wire cfg_done,
  input wire host_wr,
  input wire [1:0] host_ch,
  input wire [7:0] host_margin_code,
  input wire [1:0] host_range,
  input wire host_enable,
  input wire host_lim_wr,
  input wire [7:0] host_upper_code_limit,
  input wire [7:0] host_lower_code_limit,
  output reg host_ack_ok,
  output reg [CH*8-1:0] dac_code,
  output reg [CH*2-1:0] dac_range,
  output reg [CH-1:0] buf_power,
  output reg [CH-1:0] buf_sel_dac,
  output reg [CH-1:0] buf_drive,
  output reg [CH-1:0] buf_hiz
);
  // Last count of the tracking phase
  localparam [`MDC_CNT_W-1:0] TRACK_LAST = TRACK_CYC - `MDC_CNT_ONE;

  // Clip the written code into the inclusive limit window
  function [`MDC_CODE_W-1:0] mdc_clip;
    input [`MDC_CODE_W-1:0] code;
    input [`MDC_CODE_W-1:0] lo;
    input [`MDC_CODE_W-1:0] hi;
    begin
      if (code < lo) begin
        mdc_clip = lo;
      end else if (code > hi) begin
        mdc_clip = hi;
      end else begin
        mdc_clip = code;
      end
    end
  endfunction

  // Lower limit above upper limit
  function mdc_crossed;
    input [`MDC_CODE_W-1:0] lo;
    input [`MDC_CODE_W-1:0] hi;
    begin
      mdc_crossed = (lo > hi);
    end
  endfunction

  // Buffer powered while tracking or driving
  function mdc_st_powered;
    input [`MDC_ST_W-1:0] st;
    begin
      mdc_st_powered = (st == `MDC_ST_TRACK) || (st == `MDC_ST_DRIVE);
    end
  endfunction

  // Output stage on only while driving
  function mdc_st_driving;
    input [`MDC_ST_W-1:0] st;
    begin
      mdc_st_driving = (st == `MDC_ST_DRIVE);
    end
  endfunction

  // Host channel select decode
  function mdc_ch_hit;
    input [1:0] ch;
    input integer idx;
    begin
      mdc_ch_hit = (ch == idx[1:0]);
    end
  endfunction

  reg boot_done;
  reg next_boot_done;
  reg next_host_ack_ok;
  wire host_ok;

  // Download completion latches until reset
  always @* begin
    next_boot_done = boot_done | cfg_done;
    next_host_ack_ok = boot_done | cfg_done;
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      boot_done <= 1'b0;
    end else begin
      boot_done <= next_boot_done;
    end
  end

  // Host acknowledge stays low until the download is done
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      host_ack_ok <= 1'b0;
    end else begin
      host_ack_ok <= next_host_ack_ok;
    end
  end

  // Host writes are ignored until the download is done
  assign host_ok = boot_done;

  genvar g;
  generate
    // Per-channel settings and output sequencer
    for (g = 0; g < CH; g = g + 1) begin : ch_g
      reg [`MDC_CODE_W-1:0] code;
      reg [`MDC_CODE_W-1:0] up;
      reg [`MDC_CODE_W-1:0] lo;
      reg [`MDC_RANGE_W-1:0] rng;
      reg en;
      reg [`MDC_ST_W-1:0] st;
      reg [`MDC_CNT_W-1:0] cnt;

      reg [`MDC_CODE_W-1:0] next_code;
      reg [`MDC_CODE_W-1:0] next_up;
      reg [`MDC_CODE_W-1:0] next_lo;
      reg [`MDC_RANGE_W-1:0] next_rng;
      reg next_en;
      reg [`MDC_ST_W-1:0] next_st;
      reg [`MDC_CNT_W-1:0] next_cnt;
      reg [`MDC_CODE_W-1:0] next_dac_code;
      reg [`MDC_RANGE_W-1:0] next_dac_range;
      reg next_power;
      reg next_sel_dac;
      reg next_drive;
      reg next_hiz;

      wire sel;
      wire cfg_wr;
      wire code_wr;
      wire lim_wr;
      wire bad;
      wire ready;

      assign sel = host_ok && mdc_ch_hit(host_ch, g);
      assign cfg_wr = cfg_load && !boot_done;
      assign code_wr = sel && host_wr;
      assign lim_wr = sel && host_lim_wr;
      assign bad = mdc_crossed(lo, up);
      assign ready = en && !bad;

      // Limits: startup download first, host writes after
      always @* begin
        next_up = up;
        next_lo = lo;
        if (cfg_wr) begin
          next_up = cfg_upper_code_limit[g*`MDC_CODE_W +: `MDC_CODE_W];
          next_lo = cfg_lower_code_limit[g*`MDC_CODE_W +: `MDC_CODE_W];
        end else if (lim_wr) begin
          next_up = host_upper_code_limit;
          next_lo = host_lower_code_limit;
        end
      end

      // Code, range and enable from host writes
      always @* begin
        next_code = code;
        next_rng = rng;
        next_en = en;
        if (code_wr) begin
          next_code = host_margin_code;
          next_rng = host_range;
          next_en = host_enable;
        end
      end

      // Glitch-free enable: track the pin first, then drive
      always @* begin
        next_st = st;
        next_cnt = cnt;
        case (st)
          `MDC_ST_OFF: begin
            if (bad) begin
              next_st = `MDC_ST_HIZ;
            end else if (en) begin
              next_st = `MDC_ST_TRACK;
              next_cnt = `MDC_CNT_ZERO;
            end
          end
          `MDC_ST_TRACK: begin
            if (bad) begin
              next_st = `MDC_ST_HIZ;
            end else if (!en) begin
              next_st = `MDC_ST_OFF;
            end else if (cnt == TRACK_LAST) begin
              next_st = `MDC_ST_DRIVE;
            end else begin
              next_cnt = cnt + `MDC_CNT_ONE;
            end
          end
          `MDC_ST_DRIVE: begin
            if (bad) begin
              next_st = `MDC_ST_HIZ;
            end else if (!en) begin
              next_st = `MDC_ST_OFF;
            end
          end
          `MDC_ST_HIZ: begin
            if (!bad) begin
              next_st = `MDC_ST_OFF;
            end
          end
          default: begin
            next_st = `MDC_ST_OFF;
          end
        endcase
      end

      // Next values of the registered outputs
      always @* begin
        next_dac_code = mdc_clip(code, lo, up);
        next_dac_range = rng;
        next_power = ready && mdc_st_powered(st);
        next_sel_dac = ready && mdc_st_driving(st);
        next_drive = ready && mdc_st_driving(st);
        next_hiz = !ready || !mdc_st_driving(st);
      end

      // Limit registers
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          up <= `MDC_CODE_MAX;
          lo <= `MDC_CODE_MIN;
        end else begin
          up <= next_up;
          lo <= next_lo;
        end
      end

      // Host setting registers
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          code <= `MDC_CODE_MID;
          rng <= `MDC_RANGE_0V60;
          en <= 1'b0;
        end else begin
          code <= next_code;
          rng <= next_rng;
          en <= next_en;
        end
      end

      // Sequencer state
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          st <= `MDC_ST_OFF;
          cnt <= `MDC_CNT_ZERO;
        end else begin
          st <= next_st;
          cnt <= next_cnt;
        end
      end

      // Converter code and range
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          dac_code[g*`MDC_CODE_W +: `MDC_CODE_W] <= `MDC_CODE_MID;
          dac_range[g*`MDC_RANGE_W +: `MDC_RANGE_W] <= `MDC_RANGE_0V60;
        end else begin
          dac_code[g*`MDC_CODE_W +: `MDC_CODE_W] <= next_dac_code;
          dac_range[g*`MDC_RANGE_W +: `MDC_RANGE_W] <= next_dac_range;
        end
      end

      // Buffer control; three-stated out of reset
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          buf_power[g] <= 1'b0;
          buf_sel_dac[g] <= 1'b0;
          buf_drive[g] <= 1'b0;
          buf_hiz[g] <= 1'b1;
        end else begin
          buf_power[g] <= next_power;
          buf_sel_dac[g] <= next_sel_dac;
          buf_drive[g] <= next_drive;
          buf_hiz[g] <= next_hiz;
        end
      end
    end
  endgenerate
endmodule // mdc_margin_dac_control

// ---- common/mdc_map.vh ----
`ifndef MDC_MAP_VH
`define MDC_MAP_VH
`define MDC_CODE_W 8
`define MDC_CODE_MID 8'h7F
`define MDC_CODE_MAX 8'hFF
`define MDC_CODE_MIN 8'h00
`define MDC_RANGE_W 2
`define MDC_RANGE_0V60 2'h0
`define MDC_RANGE_0V80 2'h1
`define MDC_RANGE_1V00 2'h2
`define MDC_RANGE_1V25 2'h3
`define MDC_CH_NUM 4
`define MDC_TRACK_CYC 4'h8
`define MDC_ST_OFF 2'h0
`define MDC_ST_TRACK 2'h1
`define MDC_ST_DRIVE 2'h2
`define MDC_ST_HIZ 2'h3
`define MDC_ST_W 2
`define MDC_CNT_W 4
`define MDC_CNT_ZERO 4'h0
`define MDC_CNT_ONE 4'h1
`endif

// ---- tb/mdc_margin_dac_control_props.sv ----
`timescale 1ns/1ps
module mdc_margin_dac_control_props #(
  parameter CH = 4
) (
  input wire sys_clk,
  input wire nrst,
  input wire host_ack_ok,
  input wire [CH-1:0] buf_power,
  input wire [CH-1:0] buf_sel_dac,
  input wire [CH-1:0] buf_drive,
  input wire [CH-1:0] buf_hiz
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_arm; !buf_drive[0] [*7] ##[1:5] (buf_drive[0] || !buf_power[0]); endsequence
  chk_hiz_nodrv: assert property (buf_hiz[0] |-> !buf_drive[0]) else $error("hiz drive");
  chk_hiz_nosel: assert property (buf_hiz[0] |-> !buf_sel_dac[0]) else $error("hiz sel");
  chk_drv_sel: assert property (buf_drive[0] |-> buf_sel_dac[0]) else $error("drive sel");
  chk_sel_pow: assert property (buf_sel_dac[0] |-> buf_power[0]) else $error("sel pow");
  chk_drv_late: assert property ($rose(buf_drive[0]) |-> $past(buf_power[0])) else $error("late");
  chk_track_arm: assert property ($rose(buf_power[0]) |-> s_arm) else $error("track");
  chk_ack_keep: assert property (host_ack_ok |=> host_ack_ok) else $error("ack");
  chk_noack_off: assert property (!host_ack_ok |-> !buf_power[0]) else $error("noack");
endmodule // mdc_margin_dac_control_props
bind mdc_margin_dac_control mdc_margin_dac_control_props #(.CH(CH)) i_mdc_margin_dac_control_props (
  .sys_clk(sys_clk), .nrst(nrst), .host_ack_ok(host_ack_ok), .buf_power(buf_power),
  .buf_sel_dac(buf_sel_dac), .buf_drive(buf_drive), .buf_hiz(buf_hiz));

// ---- tb/mdc_nv_store.sv ----
`timescale 1ns/1ps
module mdc_nv_store (
  input wire sys_clk,
  input wire nrst,
  output wire cfg_load,
  output wire [31:0] cfg_upper_code_limit,
  output wire [31:0] cfg_lower_code_limit,
  output wire cfg_done
);
  reg [4:0] cnt;
  assign cfg_upper_code_limit = {4{8'hF0}};
  assign cfg_lower_code_limit = {4{8'h10}};
  assign cfg_load = cnt < 5'h14;
  assign cfg_done = cnt == 5'h14;
  always @(posedge sys_clk or negedge nrst)
    if (!nrst) cnt <= 5'h0;
    else if (!cfg_done) cnt <= cnt + 5'h1;
endmodule // mdc_nv_store

// ---- tb/mdc_margin_dac_control_tb.sv ----
`timescale 1ns/1ps
module mdc_margin_dac_control_tb;
  logic sys_clk, nrst, host_wr, host_enable, host_lim_wr;
  logic [1:0] host_ch, host_range;
  logic [7:0] host_margin_code, host_upper_code_limit, host_lower_code_limit;
  wire cfg_load, cfg_done, host_ack_ok;
  wire [31:0] cfg_upper_code_limit, cfg_lower_code_limit, dac_code;
  wire [7:0] dac_range;
  wire [3:0] buf_power, buf_sel_dac, buf_drive, buf_hiz;
  int error_cnt = 0, compares = 0, cyc = 0, i;
  always #20 sys_clk = ~sys_clk;
  mdc_nv_store i_mdc_nv_store (.sys_clk(sys_clk), .nrst(nrst), .cfg_load(cfg_load),
    .cfg_upper_code_limit(cfg_upper_code_limit), .cfg_lower_code_limit(cfg_lower_code_limit),
    .cfg_done(cfg_done));
  mdc_margin_dac_control i_mdc_margin_dac_control (.sys_clk(sys_clk), .nrst(nrst),
    .cfg_load(cfg_load), .cfg_upper_code_limit(cfg_upper_code_limit),
    .cfg_lower_code_limit(cfg_lower_code_limit), .cfg_done(cfg_done), .host_wr(host_wr),
    .host_ch(host_ch), .host_margin_code(host_margin_code), .host_range(host_range),
    .host_enable(host_enable), .host_lim_wr(host_lim_wr),
    .host_upper_code_limit(host_upper_code_limit),
    .host_lower_code_limit(host_lower_code_limit),
    .host_ack_ok(host_ack_ok), .dac_code(dac_code), .dac_range(dac_range),
    .buf_power(buf_power), .buf_sel_dac(buf_sel_dac), .buf_drive(buf_drive),
    .buf_hiz(buf_hiz));
  task chk(input [31:0] got, input [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input l, input [1:0] c, input [7:0] d, input [1:0] r, input e);
    @(posedge sys_clk) #1;
    {host_lim_wr, host_wr, host_ch, host_margin_code, host_range, host_enable} = {l, !l, c, d, r, e};
    @(posedge sys_clk) #1 {host_lim_wr, host_wr} = 2'h0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task end_sim;
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task t_boot;
    wr(0, 0, 8'h20, 2'h1, 1'h1);
    chk(host_ack_ok, 0);
    chk(dac_code, 32'h7F7F7F7F);
    chk(buf_power, 0);
    while (host_ack_ok !== 1'h1) @(posedge sys_clk);
    #1;
    chk(dac_code, 32'h7F7F7F7F);
    chk(buf_power, 0);
    $display("boot");
  endtask
  task t_clip;
    for (i = 0; i < 5; i++) begin
      wr(0, 0, 40'h051080F0FF >> (32 - 8 * i), 2'h0, 1'h0);
      chk(dac_code[7:0], 40'h101080F0F0 >> (32 - 8 * i) & 8'hFF);
    end
    $display("clip");
  endtask
  task t_chan;
    for (i = 0; i < 4; i++) wr(0, i[1:0], 8'h40 + i[7:0], i[1:0], 1'h0);
    chk(dac_range, 8'hE4);
    chk(dac_code, 32'h43424140);
    $display("chan");
  endtask
  task t_enable;
    wr(0, 0, 8'h80, 2'h0, 1'h0);
    chk(buf_power[0], 0);
    chk(dac_code[7:0], 8'h80);
    wr(0, 0, 8'h80, 2'h0, 1'h1);
    chk(buf_power[0], 1);
    chk(buf_sel_dac[0], 0);
    chk(buf_drive[0], 0);
    repeat (10) @(posedge sys_clk);
    #1;
    chk(buf_drive[0], 1);
    chk(buf_sel_dac[0], 1);
    chk(buf_hiz[0], 0);
    $display("enable");
  endtask
  task t_hiz;
    {host_lower_code_limit, host_upper_code_limit} = 16'h9080;
    wr(1, 0, 8'h00, 2'h0, 1'h0);
    chk(buf_hiz[0], 1);
    chk(buf_drive[0], 0);
    chk(buf_sel_dac[0], 0);
    chk(buf_power[0], 0);
    $display("hiz");
  endtask
  initial begin
    {sys_clk, nrst, host_wr, host_enable, host_lim_wr, host_ch, host_range} = '0;
    {host_margin_code, host_upper_code_limit, host_lower_code_limit} = '0;
    repeat (2) @(posedge sys_clk);
    #1 nrst = 1'h1;
    t_boot;
    t_clip;
    t_chan;
    t_enable;
    t_hiz;
    end_sim;
  end
  always @(posedge sys_clk) if (++cyc == 3000) begin error_cnt++; end_sim; end
endmodule // mdc_margin_dac_control_tb
